// ===== msel_regs.svh
`ifndef MSEL_REGS_SVH
`define MSEL_REGS_SVH

// register offsets, byte addresses
`define MSEL_OFS_CTRL      12'h000
`define MSEL_OFS_GRACE     12'h004
`define MSEL_OFS_FALLBACK  12'h008
`define MSEL_OFS_STATUS    12'h00C
`define MSEL_OFS_IRQ_STAT  12'h010
`define MSEL_OFS_IRQ_MASK  12'h014

// control fields
`define MSEL_CTRL_RUN      0
`define MSEL_CTRL_USE_ERR  1

// status fields
`define MSEL_ST_OUT_LSB    0
`define MSEL_ST_ERR        8
`define MSEL_ST_RUNNING    9
`define MSEL_ST_IN_LSB     16

// interrupt event bits
`define MSEL_IRQ_FAULT_SET 0
`define MSEL_IRQ_FAULT_CLR 1
`define MSEL_IRQ_INVALID   2

// reset values
`define MSEL_CTRL_RST      2'h2
`define MSEL_GRACE_RST     10'h000
`define MSEL_FALLBACK_RST  8'h00
`define MSEL_MASK_RST      3'h0

// timing
`define MSEL_CLK_MHZ       250
`define MSEL_CYCLE_MS      10
`define MSEL_GRACE_MAX_S   10
`define MSEL_GRACE_MAX     (`MSEL_GRACE_MAX_S * 1000 / `MSEL_CYCLE_MS)
`define MSEL_CYCLE_CLKS    (`MSEL_CYCLE_MS * `MSEL_CLK_MHZ * 1000)

`endif

// ===== msel_pkg.sv
package msel_pkg;

    typedef enum logic [2:0] {
        MSEL_STOP,
        MSEL_FIRST,
        MSEL_VALID,
        MSEL_GRACE,
        MSEL_FAULT
    } msel_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic [31:0] wdata;
    } msel_apb_req_t;

    typedef struct packed {
        logic use_err;
        logic run;
    } msel_ctrl_t;

endpackage

// ===== msel_sync.sv
`timescale 1ns/1ps
`default_nettype none

module msel_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);

    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;
    logic [W-1:0] nxt_q;

    // a bit changes only once stages two and three agree
    assign nxt_q = (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
    assign dout  = q_ff;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            q_ff  <= '0;
        end
        else if (ce)
        begin
            s1_ff <= din;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            q_ff  <= nxt_q;
        end
    end

endmodule

`default_nettype wire

// ===== msel_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "msel_regs.svh"

// Overview of operation
// - with exactly one selector input high, the matching output is high, the rest low, error low.
// - the number of inputs and outputs is a parameter from two to eight.
// - with zero or several inputs high, the last active output is held while grace time runs.
// - an invalid pattern lasting beyond grace time applies the fallback mask and sets error.
// - an invalid pattern in the first logic cycle after stop-to-run faults at once.
// - grace time is set from zero to ten seconds in ten millisecond steps.
// - the fallback mask drives each marked output high and each unmarked low while in error.
// - during an invalid pattern still inside grace time the error flag stays low.
module msel_top #(
    parameter int N_SEL       = 8,
    parameter int CYCLE_CLKS  = `MSEL_CYCLE_CLKS
) (
    input  wire logic             sys_clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output var  logic [31:0]      prdata,
    output var  logic             pready,
    output var  logic             pslverr,
    input  wire logic [N_SEL-1:0] sel_in,
    output var  logic [N_SEL-1:0] mode_out,
    output var  logic             err_flag,
    output var  logic             irq
);

    localparam logic [9:0]  GRACE_MAX = 10'(`MSEL_GRACE_MAX);
    localparam logic [31:0] CYC_LAST  = 32'(CYCLE_CLKS - 1);

    // width outside two..eight fails elaboration
    if (N_SEL < 2 || N_SEL > 8)
    begin : g_bad_width
        $error("selector count outside two to eight");
    end

    function automatic logic is_onehot(input logic [N_SEL-1:0] v);
        return (v != '0) && ((v & (v - N_SEL'(1))) == '0);
    endfunction

    // ---------------- register bus ----------------

    msel_pkg::msel_apb_req_t req;
    msel_pkg::msel_ctrl_t    ctrl_ff;

    logic [9:0]       grace_ff;
    logic [N_SEL-1:0] fallback_ff;
    logic [2:0]       irq_stat_ff;
    logic [2:0]       irq_mask_ff;
    logic [31:0]      prdata_ff;
    logic             pready_ff;
    logic             pslverr_ff;

    assign req.addr  = paddr;
    assign req.write = pwrite;
    assign req.wdata = pwdata;

    wire acc      = psel & penable;
    wire acc_prep = acc & ~pready_ff;
    wire acc_done = acc & pready_ff;
    wire wr_done  = acc_done & req.write;
    wire rd_done  = acc_done & ~req.write;

    wire hit_ctrl  = (req.addr == `MSEL_OFS_CTRL);
    wire hit_grace = (req.addr == `MSEL_OFS_GRACE);
    wire hit_fb    = (req.addr == `MSEL_OFS_FALLBACK);
    wire hit_stat  = (req.addr == `MSEL_OFS_STATUS);
    wire hit_ist   = (req.addr == `MSEL_OFS_IRQ_STAT);
    wire hit_imask = (req.addr == `MSEL_OFS_IRQ_MASK);
    wire hit_any   = hit_ctrl | hit_grace | hit_fb | hit_stat | hit_ist | hit_imask;

    // grace writes keep bits 9:0 only; a value above ten seconds saturates at the top step
    wire [9:0] wr_grace  = req.wdata[9:0];
    wire [9:0] nxt_grace = (wr_grace > GRACE_MAX) ? GRACE_MAX : wr_grace;

    // ---------------- selector path ----------------

    logic [N_SEL-1:0]     sel_sync;
    msel_pkg::msel_state_t state_ff;
    msel_pkg::msel_state_t nxt_state;
    logic [N_SEL-1:0]     mode_out_ff;
    logic [N_SEL-1:0]     nxt_mode;
    logic                 err_ff;
    logic                 nxt_err;
    logic [9:0]           cnt_ff;
    logic [9:0]           nxt_cnt;
    logic [31:0]          cyc_ff;
    logic                 irq_ff;

    msel_sync #(
        .W (N_SEL)
    ) u_sync (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .ce      (ce),
        .din     (sel_in),
        .dout    (sel_sync)
    );

    wire valid    = is_onehot(sel_sync);
    wire running  = (state_ff != msel_pkg::MSEL_STOP);
    wire tick     = running && (cyc_ff == CYC_LAST);
    wire [9:0] cnt_inc = (cnt_ff == 10'h3FF) ? cnt_ff : cnt_ff + 10'h001;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_mode  = mode_out_ff;
        nxt_err   = err_ff;
        nxt_cnt   = cnt_ff;
        if (!ctrl_ff.run)
        begin
            nxt_state = msel_pkg::MSEL_STOP;
            nxt_mode  = '0;
            nxt_err   = 1'b0;
            nxt_cnt   = '0;
        end
        else
        begin
            case (state_ff)
                msel_pkg::MSEL_STOP:
                begin
                    // stop-to-run restarts the block from scratch
                    nxt_state = msel_pkg::MSEL_FIRST;
                    nxt_mode  = '0;
                    nxt_err   = 1'b0;
                    nxt_cnt   = '0;
                end
                msel_pkg::MSEL_FIRST:
                begin
                    if (tick && valid)
                    begin
                        nxt_state = msel_pkg::MSEL_VALID;
                        nxt_mode  = sel_sync;
                    end
                    else if (tick)
                    begin
                        nxt_state = msel_pkg::MSEL_FAULT;
                        nxt_mode  = fallback_ff;
                        nxt_err   = ctrl_ff.use_err;
                    end
                end
                msel_pkg::MSEL_VALID,
                msel_pkg::MSEL_GRACE:
                begin
                    if (tick && valid)
                    begin
                        nxt_state = msel_pkg::MSEL_VALID;
                        nxt_mode  = sel_sync;
                        nxt_err   = 1'b0;
                        nxt_cnt   = '0;
                    end
                    else if (tick)
                    begin
                        nxt_cnt = cnt_inc;
                        if (cnt_inc > grace_ff)
                        begin
                            nxt_state = msel_pkg::MSEL_FAULT;
                            nxt_mode  = fallback_ff;
                            nxt_err   = ctrl_ff.use_err;
                        end
                        else
                        begin
                            // hold last pattern, error stays low
                            nxt_state = msel_pkg::MSEL_GRACE;
                            nxt_err   = 1'b0;
                        end
                    end
                end
                msel_pkg::MSEL_FAULT:
                begin
                    if (tick && valid)
                    begin
                        nxt_state = msel_pkg::MSEL_VALID;
                        nxt_mode  = sel_sync;
                        nxt_err   = 1'b0;
                        nxt_cnt   = '0;
                    end
                    else
                    begin
                        // mask may be rewritten while in error
                        nxt_mode = fallback_ff;
                        nxt_err  = ctrl_ff.use_err;
                    end
                end
                default:
                begin
                    nxt_state = msel_pkg::MSEL_STOP;
                    nxt_mode  = '0;
                    nxt_err   = 1'b0;
                    nxt_cnt   = '0;
                end
            endcase
        end
    end

    // ---------------- interrupt events ----------------

    wire to_fault   = (nxt_state == msel_pkg::MSEL_FAULT) &&
                      (state_ff != msel_pkg::MSEL_FAULT);
    wire from_fault = (state_ff == msel_pkg::MSEL_FAULT) &&
                      (nxt_state != msel_pkg::MSEL_FAULT);
    wire to_grace   = (nxt_state == msel_pkg::MSEL_GRACE) &&
                      (state_ff == msel_pkg::MSEL_VALID);
    wire first_bad  = to_fault && (state_ff == msel_pkg::MSEL_FIRST);

    wire [2:0] irq_ev;
    assign irq_ev[`MSEL_IRQ_FAULT_SET] = to_fault;
    assign irq_ev[`MSEL_IRQ_FAULT_CLR] = from_fault;
    assign irq_ev[`MSEL_IRQ_INVALID]   = to_grace | first_bad;

    // read clears, a new event in the same cycle wins
    wire       ist_clr      = rd_done & hit_ist;
    wire [2:0] nxt_irq_stat = (ist_clr ? 3'h0 : irq_stat_ff) | irq_ev;
    wire [2:0] nxt_mask     = wr_done && hit_imask ? req.wdata[2:0] : irq_mask_ff;
    wire       nxt_irq      = |(nxt_irq_stat & nxt_mask);

    // ---------------- read data ----------------

    wire [31:0] rd_status;
    assign rd_status[`MSEL_ST_OUT_LSB +: 8]  = 8'(mode_out_ff);
    assign rd_status[`MSEL_ST_ERR]          = err_ff;
    assign rd_status[`MSEL_ST_RUNNING]      = running;
    assign rd_status[15:10]                 = 6'h00;
    assign rd_status[`MSEL_ST_IN_LSB +: 8]   = 8'(sel_sync);
    assign rd_status[31:24]                 = 8'h00;

    wire [31:0] rd_mux =
        hit_ctrl  ? {30'h0000_0000, ctrl_ff.use_err, ctrl_ff.run} :
        hit_grace ? {22'h00_0000, grace_ff} :
        hit_fb    ? 32'(fallback_ff) :
        hit_stat  ? rd_status :
        hit_ist   ? {29'h0000_0000, irq_stat_ff} :
        hit_imask ? {29'h0000_0000, irq_mask_ff} :
                    32'h0000_0000;

    // ---------------- registers ----------------

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            // one wait state: answer comes in the second access cycle
            pready_ff  <= acc_prep;
            pslverr_ff <= acc_prep & ~hit_any;
            prdata_ff  <= (acc_prep && !req.write) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            ctrl_ff     <= msel_pkg::msel_ctrl_t'(`MSEL_CTRL_RST);
            grace_ff    <= `MSEL_GRACE_RST;
            fallback_ff <= N_SEL'(`MSEL_FALLBACK_RST);
            irq_mask_ff <= `MSEL_MASK_RST;
        end
        else if (ce && wr_done)
        begin
            if (hit_ctrl)
            begin
                ctrl_ff.run     <= req.wdata[`MSEL_CTRL_RUN];
                ctrl_ff.use_err <= req.wdata[`MSEL_CTRL_USE_ERR];
            end
            if (hit_grace)
            begin
                grace_ff <= nxt_grace;
            end
            if (hit_fb)
            begin
                fallback_ff <= req.wdata[N_SEL-1:0];
            end
            irq_mask_ff <= nxt_mask;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_ff    <= msel_pkg::MSEL_STOP;
            mode_out_ff <= '0;
            err_ff      <= 1'b0;
            cnt_ff      <= 10'h000;
            irq_stat_ff <= 3'h0;
            irq_ff      <= 1'b0;
        end
        else if (ce)
        begin
            state_ff    <= nxt_state;
            mode_out_ff <= nxt_mode;
            err_ff      <= nxt_err;
            cnt_ff      <= nxt_cnt;
            irq_stat_ff <= nxt_irq_stat;
            irq_ff      <= nxt_irq;
        end
    end

    // logic cycle timer, restarted by stop-to-run
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cyc_ff <= 32'h0000_0000;
        end
        else if (ce)
        begin
            if (!running || tick)
            begin
                cyc_ff <= 32'h0000_0000;
            end
            else
            begin
                cyc_ff <= cyc_ff + 32'h0000_0001;
            end
        end
    end

    assign prdata   = prdata_ff;
    assign pready   = pready_ff;
    assign pslverr  = pslverr_ff;
    assign mode_out = mode_out_ff;
    assign err_flag = err_ff;
    assign irq      = irq_ff;

endmodule

`default_nettype wire

// ===== msel_switch.sv
`timescale 1ns/1ps
`default_nettype none

module msel_switch #(
    parameter int N_SEL = 4
) (
    input  wire logic             sys_clk,
    input  wire logic [2:0]       pos,
    input  wire logic             lift,
    input  wire logic [N_SEL-1:0] extra,
    output var  logic [N_SEL-1:0] contacts
);
    logic [2:0] pos_ff = 3'h0;

    // detent follows the knob one edge late, like a real wafer
    always_ff @(posedge sys_clk)
    begin
        pos_ff <= pos;
    end

    // lift holds the knob between detents; extra models a welded contact
    assign contacts = (lift ? '0 : (N_SEL'(1) << pos_ff)) | extra;
endmodule

`default_nettype wire

// ===== msel_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module msel_chk #(
    parameter int N_SEL = 8
) (
    input wire logic             sys_clk,
    input wire logic             nrst,
    input wire logic             ce,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [N_SEL-1:0] sel_in,
    input wire logic [N_SEL-1:0] mode_out,
    input wire logic             err_flag,
    input wire logic             irq
);
    // shadows of written config; later writes mid-fault are not modelled
    logic [N_SEL-1:0] fb_ff;
    logic [2:0]       mask_ff;
    logic             run_ff;
    logic             use_ff;
    logic             wr_done;

    assign wr_done = ce && psel && penable && pready && pwrite;

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            fb_ff   <= '0;
            mask_ff <= 3'h0;
            run_ff  <= 1'b0;
            use_ff  <= 1'b1;
        end
        else if (wr_done)
        begin
            fb_ff   <= (paddr == 12'h008) ? pwdata[N_SEL-1:0] : fb_ff;
            mask_ff <= (paddr == 12'h014) ? pwdata[2:0] : mask_ff;
            run_ff  <= (paddr == 12'h000) ? pwdata[0] : run_ff;
            use_ff  <= (paddr == 12'h000) ? pwdata[1] : use_ff;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_rdy_wait;
        ce && psel && penable && !pready |=> pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("late answer");

    property p_rdy_pulse;
        pready |=> !pready;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready too long");

    property p_unmapped;
        ce && psel && penable && !pready && paddr > 12'h014 |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

    property p_onehot;
        // without the error flag the fallback mask shows with the flag low
        !err_flag && use_ff && $stable(use_ff) |-> $onehot0(mode_out);
    endproperty
    a_onehot: assert property (p_onehot) else $error("several outputs high");

    property p_hold;
        $changed(mode_out) |=> (!run_ff || $stable(mode_out)) [*6];
    endproperty
    a_hold: assert property (p_hold) else $error("output moved between ticks");

    property p_fallback;
        err_flag |-> mode_out == fb_ff;
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback wrong");

    property p_recover;
        $fell(err_flag) && run_ff && use_ff |-> $onehot(mode_out);
    endproperty
    a_recover: assert property (p_recover) else $error("no output after error");

    property p_irq_mask;
        mask_ff == 3'h0 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");

    c_fault: cover property ($rose(err_flag));
    c_clear: cover property ($fell(err_flag));
    c_irq: cover property ($rose(irq));
endmodule

bind msel_top msel_chk #(.N_SEL(N_SEL)) u_chk (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sel_in(sel_in), .mode_out(mode_out), .err_flag(err_flag),
    .irq(irq));

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int NS = 4;
    localparam int CC = 8;
    logic          sys_clk = 1'b0;
    logic          nrst = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [11:0]   paddr = 12'h0;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [NS-1:0] sel_in;
    logic [NS-1:0] mode_out;
    logic          err_flag;
    logic          irq;
    logic [2:0]    pos = 3'h0;
    logic          lift = 1'b1;
    logic [NS-1:0] extra = '0;
    logic          ce = 1'b1;
    logic [31:0]   rd;
    logic          rerr;
    int            failures = 0;
    int            check_count = 0;

    always #2 sys_clk = ~sys_clk;

    msel_switch #(.N_SEL(NS)) sw (.sys_clk(sys_clk), .pos(pos), .lift(lift),
        .extra(extra), .contacts(sel_in));
    msel_top #(.N_SEL(NS), .CYCLE_CLKS(CC)) dut (
        .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sel_in(sel_in), .mode_out(mode_out),
        .err_flag(err_flag), .irq(irq));

    task automatic test_done;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // idle cycle after each transfer keeps psel from being driven twice
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge sys_clk);
        end
        while (pready !== 1'b1);
        rd      = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic outs(input logic [NS-1:0] m, input logic e);
        chk("mode_out", 32'(m), 32'(mode_out));
        chk("err_flag", 32'(e), 32'(err_flag));
    endtask

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        chk("watchdog", 32'h0, 32'h1);
        test_done;
    end

    initial
    begin
        int   n;
        int   g;
        logic held;
        logic bad;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 6; i++)
        begin
            apb(12'(4 * i), 1'b0, 32'h0);
            chk("reset value", (i == 0) ? 32'h2 : 32'h0, rd);
        end
        apb(12'h018, 1'b0, 32'h0);
        chk("slverr", 32'h1, 32'(rerr));
        apb(12'h004, 1'b1, 32'h7ff);
        apb(12'h004, 1'b0, 32'h0);
        chk("grace", 32'h3e8, rd);
        apb(12'h008, 1'b1, 32'h6);
        apb(12'h014, 1'b1, 32'h7);
        // knob lifted: no contact closed when run starts
        apb(12'h000, 1'b1, 32'h3);
        repeat (14) @(posedge sys_clk);
        outs(4'h6, 1'b1);
        chk("irq", 32'h1, 32'(irq));
        apb(12'h00c, 1'b0, 32'h0);
        chk("status", 32'h306, rd);
        apb(12'h010, 1'b0, 32'h0);
        chk("irq_stat", 32'h5, rd);
        repeat (2) @(posedge sys_clk);
        chk("irq", 32'h0, 32'(irq));
        lift <= 1'b0;
        for (int p = 0; p < NS; p++)
        begin
            pos <= 3'(p);
            repeat (2 * CC) @(posedge sys_clk);
            outs(NS'(1) << p, 1'b0);
        end
        for (int k = 0; k < 2; k++)
        begin
            g = 2 - 2 * k;
            apb(12'h004, 1'b1, 32'(g));
            apb(12'h014, 1'b1, 32'(g != 0));
            apb(12'h010, 1'b0, 32'h0);
            extra <= 4'h1;
            n = 0;
            held = 1'b1;
            while (err_flag !== 1'b1 && n < 60)
            begin
                held = held && (mode_out === 4'h8);
                @(posedge sys_clk);
                n++;
            end
            chk("held", 32'h1, 32'(held));
            chk("fault delay", 32'h1, 32'(n >= g * CC + 3 && n <= g * CC + 16));
            outs(4'h6, 1'b1);
            @(posedge sys_clk);
            chk("irq", 32'(g != 0), 32'(irq));
            extra <= 4'h0;
            repeat (3 * CC) @(posedge sys_clk);
            outs(4'h8, 1'b0);
        end
        // short bounces must restart the count, never add up
        apb(12'h004, 1'b1, 32'h2);
        bad = 1'b0;
        for (int i = 0; i < 112; i++)
        begin
            extra <= (i % 28 < 12) ? 4'h1 : 4'h0;
            @(posedge sys_clk);
            bad = bad | err_flag;
        end
        chk("no fault", 32'h0, 32'(bad));
        // error flag off: fallback still applied, flag stays low
        apb(12'h004, 1'b1, 32'h0);
        apb(12'h000, 1'b1, 32'h1);
        // frozen clock enable must hide a bad pattern
        ce    <= 1'b0;
        extra <= 4'h1;
        repeat (3 * CC) @(posedge sys_clk);
        outs(4'h8, 1'b0);
        ce <= 1'b1;
        repeat (3 * CC) @(posedge sys_clk);
        outs(4'h6, 1'b0);
        extra <= 4'h0;
        repeat (3 * CC) @(posedge sys_clk);
        outs(4'h8, 1'b0);
        apb(12'h000, 1'b1, 32'h2);
        repeat (2) @(posedge sys_clk);
        outs(4'h0, 1'b0);
        test_done;
    end
endmodule

`default_nettype wire
